// >>> i2c_target.sv
// two-wire target port of the module: commands in, status out
//
// Behaviour
// - fast-mode operation, at most 400 kbit/s
// - eight-bit bytes, most significant bit first
// - receiver acknowledges every byte but the last byte read
// - busy device holds clock low, host waits
// - write carries commands, read returns status
// - answer only seven-bit address 0x40
// - data waiting pin flags pending message
// - target and controller ports share fast-mode rules
// - input filter rejects spikes up to 50 ns
// - host keeps low 1.3 us, high 0.6 us
// - pins selectable: gpio, two-wire or spi
// - hard reset low at least 10 ms, open-drain
// - host traffic and test; pull-ups at host
module i2c_target (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // pin function and service state
  input wire logic [i2c_link_pkg::PIN_SEL_W-1:0] pin_sel,
  input wire logic busy,
  // command bytes to the module
  output logic [i2c_link_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  // status bytes from the module
  input wire logic [i2c_link_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_avail,
  input wire logic tx_last,
  output logic tx_take,
  input wire logic msg_queued,
  // port state
  output logic addressed,
  output logic waiting,
  // link
  i2c_link_if.device bus
);
  import i2c_link_pkg::*;

  typedef struct packed {
    dev_state_t st;
    logic [FILT_W-1:0] scl_cnt;
    logic [FILT_W-1:0] sda_cnt;
    logic scl_f;
    logic sda_f;
    logic [BYTE_W-1:0] sh;
    logic [BIT_CNT_W-1:0] bits;
    logic is_addr;
    logic rw;
    logic first;
    logic [BYTE_W-1:0] rx_data;
    logic rx_valid;
    logic rx_first;
    logic tx_take;
    logic last_sent;
    logic waiting;
    logic sda_pull;
  } dev_t;

  dev_t s;
  dev_t next_s;
  logic rst_n;
  logic active;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic stretch;

  // filter cannot count far enough
  if (GLITCH_CYC >= 2 ** FILT_W) begin : g_chk
    $error("filter counter too narrow for spike width");
  end

  // a change is taken only after it stands past the spike width
  function automatic logic [FILT_W:0] glitch_filter(
    input logic raw,
    input logic filt,
    input logic [FILT_W-1:0] cnt
  );
    logic [FILT_W:0] r;
    r = {filt, {FILT_W{1'b0}}};
    if (raw != filt) begin
      if (cnt == FILT_W'(GLITCH_CYC)) begin
        r = {raw, {FILT_W{1'b0}}};
      end else begin
        r = {filt, cnt + 1'b1};
      end
    end
    return r;
  endfunction

  // load next status byte, filler when nothing is queued
  function automatic logic [BYTE_W+1:0] load_tx(
    input logic avail,
    input logic last,
    input logic [BYTE_W-1:0] data
  );
    logic [BYTE_W+1:0] r;
    r = {1'b0, 1'b0, IDLE_BYTE};
    if (avail) begin
      r = {1'b1, last, data};
    end
    return r;
  endfunction

  // either reset pin clears the port
  assign rst_n = reset_n & bus.external_hard_reset_n;
  assign active = (pin_sel == PIN_TWI);

  // next state
  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.tx_take = 1'b0;
    {next_s.scl_f, next_s.scl_cnt} =
      glitch_filter(bus.scl, s.scl_f, s.scl_cnt);
    {next_s.sda_f, next_s.sda_cnt} =
      glitch_filter(bus.sda, s.sda_f, s.sda_cnt);
    // edges of the filtered lines, fast enough for 400 kbit/s
    scl_rise = next_s.scl_f & ~s.scl_f;
    scl_fall = ~next_s.scl_f & s.scl_f;
    start_c = s.scl_f & next_s.scl_f & s.sda_f & ~next_s.sda_f;
    stop_c = s.scl_f & next_s.scl_f & ~s.sda_f & next_s.sda_f;
    case (s.st)
      ST_RX: begin
        if (scl_rise) begin
          next_s.sh = {s.sh[BYTE_W-2:0], next_s.sda_f};
          next_s.bits = s.bits + 1'b1;
        end else if (scl_fall && s.bits == BIT_CNT_W'(BYTE_W)) begin
          if (s.is_addr) begin
            if (s.sh[BYTE_W-1:1] == TARGET_ADDR) begin
              next_s.st = ST_ACK;
              next_s.sda_pull = 1'b1;
              next_s.rw = s.sh[0];
              next_s.first = 1'b1;
            end else begin
              next_s.st = ST_SKIP;
            end
          end else begin
            // command byte handed over, then acknowledged
            next_s.rx_data = s.sh;
            next_s.rx_valid = 1'b1;
            next_s.rx_first = s.first;
            next_s.first = 1'b0;
            next_s.st = ST_ACK;
            next_s.sda_pull = 1'b1;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          next_s.bits = '0;
          next_s.is_addr = 1'b0;
          if (s.is_addr && s.rw) begin
            {next_s.tx_take, next_s.last_sent, next_s.sh} =
              load_tx(tx_avail, tx_last, tx_data);
            next_s.sda_pull = ~next_s.sh[BYTE_W-1];
            next_s.st = ST_TX;
          end else begin
            next_s.sda_pull = 1'b0;
            next_s.st = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          next_s.bits = s.bits + 1'b1;
          if (s.bits == BIT_CNT_W'(BYTE_W - 1)) begin
            // release for the host's acknowledge
            next_s.sda_pull = 1'b0;
            next_s.st = ST_RACK;
          end else begin
            next_s.sh = {s.sh[BYTE_W-2:0], 1'b0};
            next_s.sda_pull = ~s.sh[BYTE_W-2];
          end
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          if (s.last_sent) begin
            next_s.waiting = 1'b0;
            next_s.last_sent = 1'b0;
          end
          if (next_s.sda_f) begin
            next_s.st = ST_SKIP;
          end
        end else if (scl_fall) begin
          next_s.bits = '0;
          {next_s.tx_take, next_s.last_sent, next_s.sh} =
            load_tx(tx_avail, tx_last, tx_data);
          next_s.sda_pull = ~next_s.sh[BYTE_W-1];
          next_s.st = ST_TX;
        end
      end
      ST_SKIP: begin
        next_s.sda_pull = 1'b0;
      end
      ST_IDLE: begin
        next_s.sda_pull = 1'b0;
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.sda_pull = 1'b0;
      end
    endcase
    // start and stop override any byte state
    if (!active) begin
      next_s.st = ST_IDLE;
      next_s.sda_pull = 1'b0;
    end else if (start_c) begin
      next_s.st = ST_RX;
      next_s.bits = '0;
      next_s.is_addr = 1'b1;
      next_s.sda_pull = 1'b0;
    end else if (stop_c) begin
      next_s.st = ST_IDLE;
      next_s.sda_pull = 1'b0;
    end
    // new message wins over the clear in the same cycle
    if (msg_queued) begin
      next_s.waiting = 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.scl_f <= 1'b1;
      s.sda_f <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // hold clock low while busy, only in our own transfer
  assign stretch = active && busy && !s.scl_f &&
                   (s.st != ST_IDLE) && (s.st != ST_SKIP) &&
                   !(s.st == ST_RX && s.is_addr);

  // lines only ever pulled low; the high level is the host pull-up
  assign bus.scl_dev_o = 1'b0;
  assign bus.scl_dev_oe = stretch;
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = s.sda_pull;
  // pending message flag on its own pin, shared with spi
  assign bus.data_waiting_pin = s.waiting;

  // user side
  assign rx_data = s.rx_data;
  assign rx_valid = s.rx_valid;
  assign rx_first = s.rx_first;
  assign tx_take = s.tx_take;
  assign waiting = s.waiting;
  assign addressed = (s.st == ST_ACK) || (s.st == ST_TX) ||
                     (s.st == ST_RACK) || (s.st == ST_RX && !s.is_addr);
endmodule

// >>> i2c_link_pkg.sv
// shared constants and state codes for the two-wire host control link
package i2c_link_pkg;
  // clock rate and derived period
  localparam int CLK_MHZ = 25;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  // fast-mode bit rate and phase times
  localparam int FM_KBPS = 400;
  localparam int BIT_NS = 1_000_000 / FM_KBPS;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_NS = 1300;
  localparam int LOW_CYC = (LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_NS = 600;
  localparam int HIGH_MIN_CYC = (HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = (BIT_CYC - LOW_CYC > HIGH_MIN_CYC) ?
                            (BIT_CYC - LOW_CYC) : HIGH_MIN_CYC;
  localparam int HOLD_NS = 100;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // spike filter
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_W = 2;
  // hard reset hold
  localparam int RESET_HOLD_MS = 10;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * 1000 * CLK_MHZ;
  // widths
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_CNT_W = 4;
  localparam int PIN_SEL_W = 2;
  // address, pin functions, filler byte
  localparam logic [ADDR_W-1:0] TARGET_ADDR = 7'h40;
  localparam logic [PIN_SEL_W-1:0] PIN_GPIO = 2'h0;
  localparam logic [PIN_SEL_W-1:0] PIN_TWI = 2'h1;
  localparam logic [PIN_SEL_W-1:0] PIN_SPI = 2'h2;
  localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'hff;
  // target states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RX = 3'b001, ST_ACK = 3'b010,
    ST_TX = 3'b011, ST_RACK = 3'b100, ST_SKIP = 3'b101
  } dev_state_t;
  // controller states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b010,
    H_NEXT = 3'b011, H_STOP = 3'b100, H_RESET = 3'b101
  } host_state_t;
endpackage

// >>> i2c_link_if.sv
// open-drain two-wire link, data waiting pin and hard reset wire
interface i2c_link_if;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic rst_host_o;
  logic rst_host_oe;
  logic data_waiting_pin;
  logic scl;
  logic sda;
  logic external_hard_reset_n;
  // wired-and with pull-ups: released lines read high
  assign scl = ~((scl_dev_oe & ~scl_dev_o) | (scl_host_oe & ~scl_host_o));
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
  assign external_hard_reset_n = ~(rst_host_oe & ~rst_host_o);
  modport device (
    input scl, sda, external_hard_reset_n,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, data_waiting_pin
  );
  modport host (
    input scl, sda, data_waiting_pin,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
    output rst_host_o, rst_host_oe
  );
endinterface

// >>> i2c_controller.sv
// host end: fast-mode two-wire controller and hard reset driver
module i2c_controller #(
  parameter int CNT_W = 7,
  parameter int RST_W = 18,
  parameter int RESET_CYC = i2c_link_pkg::RESET_HOLD_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // transfer request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [i2c_link_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [i2c_link_pkg::BYTE_W-1:0] cmd_len,
  // write bytes
  input wire logic [i2c_link_pkg::BYTE_W-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read bytes and completion
  output logic [i2c_link_pkg::BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack,
  output logic msg_waiting,
  // hard reset request
  input wire logic reset_req,
  // link
  i2c_link_if.host bus
);
  import i2c_link_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [1:0] phase;
    logic [CNT_W-1:0] cnt;
    logic [BIT_CNT_W-1:0] bits;
    logic [BYTE_W:0] frame;
    logic [BYTE_W:0] rx;
    logic cur_bit;
    logic read;
    logic is_addr;
    logic [BYTE_W-1:0] len;
    logic [BYTE_W-1:0] rd_data;
    logic rd_valid;
    logic done;
    logic nack;
    logic waiting;
    logic [RST_W-1:0] rst_cnt;
  } host_t;

  host_t s;
  host_t next_s;
  logic scl_low;

  // counters must hold the phase and reset lengths
  if (LOW_CYC >= 2 ** CNT_W || HIGH_CYC >= 2 ** CNT_W ||
      RESET_CYC < 1 || RESET_CYC >= 2 ** RST_W) begin : g_chk
    $error("counter widths do not fit timing");
  end

  // next state
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.done = 1'b0;
    next_s.waiting = bus.data_waiting_pin;
    scl_low = 1'b0;
    wr_ready = 1'b0;
    case (s.st)
      H_IDLE: begin
        next_s.cur_bit = 1'b1;
        next_s.cnt = '0;
        next_s.phase = 2'h0;
        if (reset_req) begin
          next_s.rst_cnt = '0;
          next_s.st = H_RESET;
        end else if (cmd_valid) begin
          next_s.read = cmd_read;
          next_s.len = cmd_len;
          next_s.frame = {cmd_addr, cmd_read, 1'b1};
          next_s.is_addr = 1'b1;
          next_s.nack = 1'b0;
          next_s.cur_bit = 1'b0;
          next_s.st = H_START;
        end
      end
      H_START: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CNT_W'(HIGH_CYC - 1)) begin
          next_s.cnt = '0;
          next_s.bits = '0;
          next_s.st = H_BIT;
        end
      end
      H_BIT: begin
        if (s.phase == 2'h0) begin
          // low phase, data changes after the hold time
          scl_low = 1'b1;
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(HOLD_CYC - 1)) begin
            next_s.cur_bit = s.frame[BYTE_W];
            next_s.frame = {s.frame[BYTE_W-1:0], 1'b0};
          end
          if (s.cnt == CNT_W'(LOW_CYC - 1)) begin
            next_s.cnt = '0;
            next_s.phase = 2'h1;
          end
        end else if (!bus.scl) begin
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(HIGH_CYC - 1)) begin
            next_s.rx = {s.rx[BYTE_W-1:0], bus.sda};
            next_s.bits = s.bits + 1'b1;
            next_s.cnt = '0;
            next_s.phase = 2'h0;
            if (s.bits == BIT_CNT_W'(BYTE_W)) begin
              next_s.st = H_NEXT;
            end
          end
        end
      end
      H_NEXT: begin
        scl_low = 1'b1;
        next_s.bits = '0;
        if (!s.is_addr && s.read) begin
          next_s.rd_data = s.rx[BYTE_W:1];
          next_s.rd_valid = !s.rd_valid;
        end
        if ((s.is_addr || !s.read) && s.rx[0]) begin
          next_s.nack = 1'b1;
          next_s.st = H_STOP;
        end else if (s.len == '0) begin
          next_s.st = H_STOP;
        end else if (s.read) begin
          // acknowledge all but the last byte read
          next_s.frame = {IDLE_BYTE, s.len == 8'h01};
          next_s.len = s.len - 1'b1;
          next_s.is_addr = 1'b0;
          next_s.st = H_BIT;
        end else if (wr_valid) begin
          wr_ready = 1'b1;
          next_s.frame = {wr_data, 1'b1};
          next_s.len = s.len - 1'b1;
          next_s.is_addr = 1'b0;
          next_s.st = H_BIT;
        end
      end
      H_STOP: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.phase == 2'h0) begin
          scl_low = 1'b1;
          if (s.cnt == CNT_W'(HOLD_CYC - 1)) begin
            next_s.cur_bit = 1'b0;
          end
          if (s.cnt == CNT_W'(LOW_CYC - 1)) begin
            next_s.cnt = '0;
            next_s.phase = 2'h1;
          end
        end else if (s.phase == 2'h1) begin
          if (!bus.scl) begin
            next_s.cnt = '0;
          end else if (s.cnt == CNT_W'(HIGH_CYC - 1)) begin
            next_s.cur_bit = 1'b1;
            next_s.cnt = '0;
            next_s.phase = 2'h2;
          end
        end else if (s.cnt == CNT_W'(LOW_CYC - 1)) begin
          next_s.done = 1'b1;
          next_s.st = H_IDLE;
        end
      end
      H_RESET: begin
        next_s.rst_cnt = s.rst_cnt + 1'b1;
        if (s.rst_cnt == RST_W'(RESET_CYC - 1)) begin
          next_s.st = H_IDLE;
        end
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.cur_bit <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // open-drain drives on the target pair, reset only pulled low
  assign bus.scl_host_o = 1'b0;
  assign bus.scl_host_oe = scl_low;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = ~s.cur_bit;
  assign bus.rst_host_o = 1'b0;
  assign bus.rst_host_oe = (s.st == H_RESET);

  // user side
  assign cmd_ready = (s.st == H_IDLE) && !reset_req;
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign done = s.done;
  assign nack = s.nack;
  assign msg_waiting = s.waiting;
endmodule

// >>> i2c_link_checker.sv
// assertions on the shared two-wire link and hard reset wire
module i2c_link_checker #(
  parameter int RST_HOLD = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // target port selected for the two-wire function
  input wire logic twi_sel,
  // resolved wires
  input wire logic scl,
  input wire logic sda,
  input wire logic external_hard_reset_n,
  // pull enables of both ends
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic rst_host_oe
);
  import i2c_link_pkg::*;
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic first;
    logic rd;
    logic foreign;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rst;
  } mon_t;
  mon_t mon;
  mon_t next_mon;
  logic rise;
  logic frame;
  // clock rise, start or stop
  assign rise = scl && !mon.scl_q;
  assign frame = scl && mon.scl_q && sda != mon.sda_q;
  // bit position, address decode, saturating phase lengths
  always_comb begin
    next_mon = mon;
    next_mon.scl_q = scl;
    next_mon.sda_q = sda;
    next_mon.hi = scl ? mon.hi + {7'h00, mon.hi != 8'hff} : 8'h00;
    next_mon.lo = !scl ? mon.lo + {7'h00, mon.lo != 8'hff} : 8'h00;
    next_mon.rst = rst_host_oe ? mon.rst + {7'h00, mon.rst != 8'hff} : 8'h00;
    if (frame) begin
      next_mon.cnt = 4'h0;
      next_mon.first = !sda;
      next_mon.foreign = 1'b0;
    end else if (rise) begin
      next_mon.sh = {mon.sh[6:0], sda};
      next_mon.cnt = mon.cnt == 4'h9 ? 4'h1 : mon.cnt + 4'h1;
      if (mon.cnt == 4'h9)
        next_mon.first = 1'b0;
      if (mon.first && mon.cnt == 4'h6)
        next_mon.foreign = {mon.sh[5:0], sda} != TARGET_ADDR;
      if (mon.first && mon.cnt == 4'h7)
        next_mon.rd = sda;
    end
  end
  // monitor state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      mon <= '{scl_q: 1'b1, sda_q: 1'b1, default: '0};
    else
      mon <= next_mon;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ack slots: device acks own address and write bytes
  a_rx_ack: assert property (
    twi_sel && rise && mon.cnt == 4'h8 && !mon.foreign &&
    (mon.first || !mon.rd)
    |-> !sda) else $error("device ack missing");
  a_host_ack: assert property (
    rise && mon.cnt == 4'h8 && !mon.first && mon.rd |-> !sda_dev_oe)
    else $error("device drives host ack slot");
  a_foreign_quiet: assert property (
    mon.foreign |-> !sda_dev_oe && !scl_dev_oe)
    else $error("device drives after foreign address");
  a_sda_steady: assert property (
    $changed(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device data moved with clock high");
  a_stretch_low: assert property (
    $rose(scl_dev_oe) |-> !$past(scl))
    else $error("stretch started on high clock");
  a_host_wait: assert property (
    !scl && !scl_host_oe |=> $stable(sda_host_oe))
    else $error("host moved data during stretch");
  a_low_min: assert property (
    $rose(scl) |-> mon.lo >= LOW_CYC - 1)
    else $error("clock low phase too short");
  a_high_min: assert property (
    $fell(scl) |-> mon.hi >= HIGH_MIN_CYC)
    else $error("clock high phase too short");
  a_reset_quiet: assert property (
    !external_hard_reset_n |-> !sda_dev_oe && !scl_dev_oe)
    else $error("device drives link in hard reset");
  a_reset_long: assert property (
    $fell(rst_host_oe) |-> mon.rst >= RST_HOLD)
    else $error("hard reset pulse too short");
endmodule

// >>> testbench.sv
// self-checking bench: controller and target joined over the link
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_link_pkg::*;
  localparam int RST_CYC = 20;
  // clock, reset and user-side stimulus
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic busy = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic reset_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_avail = 1'b0;
  logic tx_last = 1'b0;
  logic msg_queued = 1'b0;
  logic [1:0] pin_sel = PIN_TWI;
  // design outputs
  logic [7:0] rx_data;
  logic [7:0] rd_data;
  logic rx_valid, rx_first, tx_take, waiting, addressed;
  logic [7:0] exp_byte;
  logic cmd_ready, wr_ready, rd_valid, done, nack, msg_waiting;
  // reference model
  logic [7:0] wq[$];
  logic [7:0] exp_rx[$];
  logic [7:0] exp_rd[$];
  logic [7:0] msg[$];
  logic [6:0] bad[4] = '{7'h01, 7'h41, 7'h00, 7'h7f};
  logic exp_first = 1'b0;
  int stretch_seen = 0;
  int err_count = 0;
  int checks_done = 0;
  i2c_link_if link ();
  i2c_target i2c_target_inst (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .pin_sel(pin_sel),
    .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_first(rx_first), .tx_data(tx_data), .tx_avail(tx_avail),
    .tx_last(tx_last), .tx_take(tx_take), .msg_queued(msg_queued),
    .addressed(addressed), .waiting(waiting), .bus(link.device));
  i2c_controller #(.RESET_CYC(RST_CYC)) i2c_controller_inst (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nack(nack),
    .msg_waiting(msg_waiting), .reset_req(reset_req), .bus(link.host));
  i2c_link_checker #(.RST_HOLD(RST_CYC)) i2c_link_checker_inst (
    .mclk(mclk), .reset_n(reset_n), .twi_sel(pin_sel == PIN_TWI),
    .scl(link.scl), .sda(link.sda),
    .external_hard_reset_n(link.external_hard_reset_n),
    .scl_dev_oe(link.scl_dev_oe), .sda_dev_oe(link.sda_dev_oe),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .rst_host_oe(link.rst_host_oe));
  // clock
  always #(CLK_NS / 2) mclk = ~mclk;
  task automatic check(input logic [7:0] got, input logic [7:0] want,
                       input string what);
    checks_done++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // received bytes, read bytes, queue pops
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      check(rx_first, exp_first, "first flag");
      check(addressed, 1'b1, "addressed");
      exp_first = 1'b0;
      exp_byte = exp_rx.size() ? exp_rx.pop_front() : 8'hxx;
      check(rx_data, exp_byte, "rx");
    end
    if (rd_valid === 1'b1) begin
      exp_byte = exp_rd.size() ? exp_rd.pop_front() : 8'hxx;
      check(rd_data, exp_byte, "rd");
    end
    if (tx_take === 1'b1) begin
      check(8'(msg.size() != 0), 8'h01, "take");
      if (msg.size() > 0)
        void'(msg.pop_front());
    end
    if (wr_ready === 1'b1 && wq.size() > 0)
      void'(wq.pop_front());
    if (link.scl_dev_oe === 1'b1)
      stretch_seen++;
  end
  // byte offers to both ends, off the sampling edge
  always @(negedge mclk) begin
    wr_valid <= wq.size() > 0;
    wr_data <= wq.size() ? wq[0] : 8'h00;
    tx_avail <= msg.size() > 0;
    tx_last <= msg.size() == 1;
    tx_data <= msg.size() ? msg[0] : 8'h00;
  end
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] n);
    int k;
    exp_first = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_len = n;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 100);
    @(negedge mclk);
    cmd_valid = 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (done !== 1'b1 && k < 20000);
    check(8'(k < 20000), 8'h01, "done");
  endtask
  task automatic write_msg(input logic [6:0] a, input int n,
                           input logic foreign);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      wq.push_back(b);
      if (!foreign)
        exp_rx.push_back(b);
    end
    xfer(1'b0, a, 8'(n));
    check(nack, foreign, "nack");
    check(8'(exp_rx.size()), 8'h00, "rx count");
    wq.delete();
  endtask
  task automatic queue_msg();
    @(negedge mclk);
    msg_queued = 1'b1;
    @(negedge mclk);
    msg_queued = 1'b0;
    repeat (2) @(negedge mclk);
    check(link.data_waiting_pin, 1'b1, "waiting pin");
    check(msg_waiting, 1'b1, "host waiting");
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h603b));
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    for (int t = 1; t <= 4; t++)
      write_msg(TARGET_ADDR, t, 1'b0);
    $display("test write done");
    foreach (bad[i])
      write_msg(bad[i], 1, 1'b1);
    // port switched to another pin function ignores its own address
    @(negedge mclk);
    pin_sel = PIN_GPIO;
    write_msg(TARGET_ADDR, 1, 1'b1);
    @(negedge mclk);
    pin_sel = PIN_TWI;
    $display("test foreign done");
    fork
      begin
        repeat (700) @(negedge mclk);
        @(negedge link.scl);
        @(negedge mclk);
        busy = 1'b1;
        repeat (300) @(negedge mclk);
        busy = 1'b0;
      end
    join_none
    stretch_seen = 0;
    write_msg(TARGET_ADDR, 3, 1'b0);
    check(8'(stretch_seen > 0), 8'h01, "stretch");
    $display("test stretch done");
    for (int i = 0; i < 3; i++)
      msg.push_back(8'($urandom));
    exp_rd = msg;
    exp_rd.push_back(IDLE_BYTE);
    queue_msg();
    xfer(1'b1, TARGET_ADDR, 8'h04);
    check(nack, 1'b0, "read nack");
    check(8'(exp_rd.size()), 8'h00, "rd count");
    check(link.data_waiting_pin, 1'b0, "waiting clear");
    $display("test read done");
    msg.push_back(8'h5a);
    queue_msg();
    @(negedge mclk);
    reset_req = 1'b1;
    @(negedge mclk);
    reset_req = 1'b0;
    for (int k = 0; k < 200 && link.external_hard_reset_n !== 1'b1; k++)
      @(negedge mclk);
    check(link.data_waiting_pin, 1'b0, "reset clears");
    msg.delete();
    write_msg(TARGET_ADDR, 2, 1'b0);
    $display("test hard reset done");
    finish_test();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
